// File: bench/smtc_slave_model.sv
// Behavioural serial slave that answers the master on the selected pins
`timescale 1ns/1ps
module smtc_slave_model (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel,
  input  wire logic [1:0] mode,
  input  wire logic       lsb,
  input  wire logic [7:0] reply,
  output logic            miso,
  output logic [7:0]      got,
  output int              nbits
);
  int o;

  initial begin
    miso = 1'b0;
    got = 8'h00;
    nbits = 0;
    o = 0;
  end

  function automatic logic bitv(input int i);
    return lsb ? reply[i%8] : reply[7-(i%8)];
  endfunction

  // Phase zero puts the first bit out as soon as the slave is selected
  always @(posedge sel) begin
    nbits = 0;
    o = mode[0] ? 0 : 1;
    if (!mode[0]) miso = bitv(0);
  end

  // No pull on the line: a released line shows the inverse of its last value
  always @(negedge sel) miso = ~miso;

  // One bit in on the sampling edge, one bit out on the other
  always @(sck) begin
    if (sel) begin
      if ((sck != mode[1]) != mode[0]) begin
        got = lsb ? {mosi, got[7:1]} : {got[6:0], mosi};
        nbits++;
      end else begin
        miso = bitv(o);
        o++;
      end
    end
  end
endmodule

// File: bench/spi_master_transaction_core_test.sv
// Self-checking bench of the serial master transaction core
`timescale 1ns/1ps
module spi_master_transaction_core_test;
  import smtc_pkg::*;
  typedef struct {
    bit [1:0] mode;
    bit       lsb;
    int       tl;
    int       rl;
    bit [7:0] reply;
  } smtc_row_s;

  logic        mclk, nrst, enable, start_task, stop_task, tx_valid, sel;
  smtc_cfg_s   cfg;
  smtc_psel_s  psel;
  logic [15:0] transmit_byte_limit, receive_byte_limit;
  logic [7:0]  tx_data, over_read_char, rx_data, last_rx, got;
  logic        tx_take, rx_valid, miso;
  smtc_evt_s   evt;
  logic [31:0] pin_out, pin_oe_n, pin_in;
  int          nbits, err_count, compares;
  int          n_td, n_rd, n_end, n_stop, n_rx, n_take;
  smtc_row_s   rows[5] = '{'{2'h0, 1'b0, 1, 1, 8'hc3},
                           '{2'h1, 1'b1, 2, 1, 8'h96},
                           '{2'h2, 1'b0, 1, 2, 8'h3c},
                           '{2'h3, 1'b1, 3, 3, 8'h81},
                           '{2'h0, 1'b0, 0, 0, 8'h00}};

  assign pin_in = {19'h0, miso, 12'h0};

  // Default half period, rounded down, runs the serial clock at or above its nominal rate
  smtc_core dut (
    .mclk(mclk), .nrst(nrst), .enable(enable), .start_task(start_task),
    .stop_task(stop_task), .cfg(cfg), .psel(psel),
    .transmit_byte_limit(transmit_byte_limit),
    .receive_byte_limit(receive_byte_limit),
    .over_read_char(over_read_char), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_take(tx_take), .rx_data(rx_data),
    .rx_valid(rx_valid), .evt(evt), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n));

  smtc_slave_model slave (
    .sck(pin_out[3]), .mosi(pin_out[7]), .sel(sel), .mode(cfg.mode),
    .lsb(cfg.lsb_first), .reply(rows[0].reply), .miso(miso), .got(got),
    .nbits(nbits));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    n_td += evt.transmit_done_event;
    n_rd += evt.receive_done_event;
    n_end += evt.end_event;
    n_stop += evt.stopped_event;
    n_take += tx_take;
    if (rx_valid) begin
      n_rx++;
      last_rx = rx_data;
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic clr();
    {n_td, n_rd, n_end, n_stop, n_rx, n_take} = '0;
  endtask

  task automatic pulse(input bit stop);
    if (stop) stop_task = 1'b1;
    else start_task = 1'b1;
    @(negedge mclk);
    {start_task, stop_task} = 2'h0;
  endtask

  task automatic run(input smtc_row_s r);
    int n, mx;
    mx = r.tl > r.rl ? r.tl : r.rl;
    cfg = '{mode: smtc_mode_e'(r.mode), lsb_first: r.lsb};
    transmit_byte_limit = 16'(r.tl);
    receive_byte_limit = 16'(r.rl);
    rows[0].reply = r.reply;
    clr();
    // Idle clock follows the new polarity; select only once it settles
    @(negedge mclk);
    sel = 1'b1;
    @(negedge mclk);
    pulse(1'b0);
    n = 0;
    while (n_end == 0 && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    repeat (3) @(negedge mclk);
    sel = 1'b0;
    chk("end_event", n_end, 1);
    chk("tx_done", n_td, 1);
    chk("rx_done", n_rd, 1);
    chk("rx_count", n_rx, r.rl);
    chk("tx_count", n_take, r.tl);
    chk("slave_bits", nbits, 8 * mx);
    if (r.rl > 0) chk("rx_data", last_rx, r.reply);
    if (mx > 0) chk("slave_got", got, r.tl >= mx ? 8'h5a : 8'ha7);
    chk("sck_idle", pin_out[3], r.mode[1]);
    chk("mosi_idle", pin_out[7], 1'b0);
  endtask

  task automatic wrap_up();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #100000;
    err_count++;
    wrap_up();
  end

  initial begin
    {nrst, enable, start_task, stop_task, sel} = 5'h00;
    {err_count, compares} = '0;
    clr();
    cfg = '{mode: bus_mode_zero, lsb_first: 1'b0};
    // Distinct pins, fixed before enable and never touched while enabled
    psel = '{sck: 5'h03, mosi: 5'h07, miso: 5'h0c};
    {transmit_byte_limit, receive_byte_limit} = '0;
    {tx_data, over_read_char, tx_valid} = {8'h5a, 8'ha7, 1'b1};
    repeat (10) @(negedge mclk);
    chk("reset_oe", pin_oe_n, 32'hffffffff);
    chk("reset_evt", evt, 4'h0);
    nrst = 1'b1;
    enable = 1'b1;
    repeat (3) @(negedge mclk);
    chk("oe_pins", pin_oe_n, 32'hffffff77);
    chk("sck_level", pin_out[3], 1'b0);
    foreach (rows[i]) run(rows[i]);
    // Stop while idle gives only the stopped event
    clr();
    pulse(1'b1);
    repeat (5) @(negedge mclk);
    chk("idle_stop", n_stop, 1);
    chk("idle_stop_td", n_td, 0);
    chk("idle_stop_rd", n_rd, 0);
    // Stop in mid-transfer forces both done events and the end event
    cfg = '{mode: bus_mode_zero, lsb_first: 1'b0};
    {transmit_byte_limit, receive_byte_limit} = {16'h0003, 16'h0003};
    clr();
    sel = 1'b1;
    pulse(1'b0);
    // Lands in the middle of the second byte
    repeat (300) @(negedge mclk);
    pulse(1'b1);
    repeat (6) @(negedge mclk);
    sel = 1'b0;
    chk("stopped", n_stop, 1);
    chk("forced_rx", n_rd, 1);
    chk("forced_tx", n_td, 1);
    chk("stop_end", n_end, 1);
    chk("partial", n_rx, 1);
    // Disabled master frees its pins and ignores a start
    enable = 1'b0;
    repeat (2) @(negedge mclk);
    clr();
    pulse(1'b0);
    repeat (10) @(negedge mclk);
    chk("off_oe", pin_oe_n, 32'hffffffff);
    chk("off_start", n_td + n_rd + n_take, 0);
    wrap_up();
  end
endmodule

// File: rtl/smtc_core.sv
// Serial master transaction core: byte shifter, sequencing, events
// Operation
// - Modes zero to three; polarity is mode bit 1, phase bit 0.
// - No chip select output; software selects slaves via other pins.
// - Start task begins a transaction; stop task ends it.
// - Transmit done fires after the transmit byte limit is shifted out.
// - Receive done fires after the receive byte limit is received.
// - End event fires once both done events have occurred.
// - Stop task halts the master, then the stopped event fires.
// - Receive done fires at the stop if still outstanding.
// - Transmit done fires at the stop if still outstanding.
// - Every byte shifted out has one byte shifted in alongside.
// - Clock, data out and data in go to the selected pins.
// - Clock and data-out pin selections act only while enabled; data in is always selected.
`timescale 1ns/1ps
`include "smtc_defines.svh"
module smtc_core
  import smtc_pkg::*;
#(
  parameter int       CW   = `SMTC_CNT_W,
  parameter int       PW   = `SMTC_PSEL_W,
  parameter bit [7:0] HALF = 8'(`SMTC_SCK_HALF_CYC)
) (
  input  logic               mclk,
  input  logic               nrst,
  input  logic               enable,
  input  logic               start_task,
  input  logic               stop_task,
  input  smtc_cfg_s          cfg,
  input  smtc_psel_s         psel,
  input  logic [CW-1:0]      transmit_byte_limit,
  input  logic [CW-1:0]      receive_byte_limit,
  input  logic [7:0]         over_read_char,
  input  logic [7:0]         tx_data,
  input  logic               tx_valid,
  output logic               tx_take,
  output logic [7:0]         rx_data,
  output logic               rx_valid,
  output smtc_evt_s          evt,
  input  logic [(1<<PW)-1:0] pin_in,
  output logic [(1<<PW)-1:0] pin_out,
  output logic [(1<<PW)-1:0] pin_oe_n
);

  smtc_state_e   state;
  smtc_mode_e    mode_q;
  logic          lsb_q;
  logic [7:0]    hcnt;
  logic          sck_act;
  logic [2:0]    bitn;
  logic [7:0]    tsr;
  logic [7:0]    rsr;
  logic          mosi_q;
  logic [CW-1:0] bcnt;
  logic [CW-1:0] bcnt_nx;
  logic [CW-1:0] txlim_q;
  logic [CW-1:0] rxlim_q;
  logic          in_txn;
  logic          txd;
  logic          rxd;
  logic          miso_s;
  logic          sck_lvl;
  logic          start_ok;
  logic          halt_req;
  logic          tx_more;
  logic          tx_fire;
  logic          rx_fire;
  logic [7:0]    load_byte;
  logic [7:0]    rx_now;

  function automatic logic [7:0] rev8(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      rev8[i] = b[7-i];
    end
  endfunction

  function automatic logic [CW-1:0] lim_max(input logic [CW-1:0] a,
                                             input logic [CW-1:0] b);
    lim_max = (a > b) ? a : b;
  endfunction

  assign start_ok = enable && start_task && !stop_task
                    && state == s_idle;
  assign halt_req = stop_task || !enable;
  assign tx_more  = bcnt < txlim_q;
  assign bcnt_nx  = bcnt + 1'b1;
  // Past the transmit limit the over-read character fills the byte
  assign load_byte = lsb_q ? rev8(tx_more ? tx_data : over_read_char)
                           : (tx_more ? tx_data : over_read_char);
  assign rx_now = mode_q[0] ? {rsr[6:0], miso_s} : rsr;
  // Idle clock follows the live polarity so it is right before start
  assign sck_lvl = (state == s_idle ? cfg.mode[1] : mode_q[1])
                   ^ sck_act;

  // Sequencer and shifter
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state    <= s_idle;
      mode_q   <= bus_mode_zero;
      lsb_q    <= 1'b0;
      hcnt     <= 8'h00;
      sck_act  <= 1'b0;
      bitn     <= 3'h0;
      tsr      <= 8'h00;
      rsr      <= 8'h00;
      mosi_q   <= `SMTC_MOSI_IDLE;
      bcnt     <= '0;
      txlim_q  <= '0;
      rxlim_q  <= '0;
      tx_take  <= 1'b0;
      rx_data  <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      tx_take  <= 1'b0;
      rx_valid <= 1'b0;
      unique case (state)
        s_idle: begin
          if (stop_task) begin
            state <= s_halt;
          end else if (start_ok) begin
            mode_q  <= cfg.mode;
            lsb_q   <= cfg.lsb_first;
            txlim_q <= transmit_byte_limit;
            rxlim_q <= receive_byte_limit;
            bcnt    <= '0;
            if (lim_max(transmit_byte_limit, receive_byte_limit) != '0) begin
              state <= s_load;
            end
          end
        end
        s_load: begin
          if (halt_req) begin
            state <= s_halt;
          end else if (!tx_more || tx_valid) begin
            // Stalls here while the source has no byte ready
            tx_take <= tx_more;
            if (!mode_q[0]) begin
              mosi_q <= load_byte[7];
              tsr    <= {load_byte[6:0], 1'b0};
            end else begin
              tsr <= load_byte;
            end
            hcnt    <= 8'h00;
            sck_act <= 1'b0;
            bitn    <= 3'h0;
            state   <= s_shift;
          end
        end
        s_shift: begin
          if (halt_req) begin
            sck_act <= 1'b0;
            mosi_q  <= `SMTC_MOSI_IDLE;
            state   <= s_halt;
          end else if (hcnt == HALF - 8'h01) begin
            hcnt    <= 8'h00;
            sck_act <= !sck_act;
            if (!sck_act) begin
              if (mode_q[0]) begin
                mosi_q <= tsr[7];
                tsr    <= {tsr[6:0], 1'b0};
              end else begin
                rsr <= {rsr[6:0], miso_s};
              end
            end else begin
              if (mode_q[0]) begin
                rsr <= {rsr[6:0], miso_s};
              end else if (bitn != `SMTC_BIT_LAST) begin
                mosi_q <= tsr[7];
                tsr    <= {tsr[6:0], 1'b0};
              end
              bitn <= bitn + 3'h1;
              if (bitn == `SMTC_BIT_LAST) begin
                rx_data  <= lsb_q ? rev8(rx_now) : rx_now;
                rx_valid <= bcnt < rxlim_q;
                bcnt     <= bcnt_nx;
                if (bcnt_nx >= lim_max(txlim_q, rxlim_q)) begin
                  mosi_q <= `SMTC_MOSI_IDLE;
                  state  <= s_idle;
                end else begin
                  state <= s_load;
                end
              end
            end
          end else begin
            hcnt <= hcnt + 8'h01;
          end
        end
        s_halt: begin
          sck_act <= 1'b0;
          mosi_q  <= `SMTC_MOSI_IDLE;
          state   <= s_idle;
        end
      endcase
    end
  end

  assign tx_fire = in_txn && !txd
                   && (bcnt >= txlim_q || state == s_halt);
  assign rx_fire = in_txn && !rxd
                   && (bcnt >= rxlim_q || state == s_halt);

  // Transaction events
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      in_txn <= 1'b0;
      txd    <= 1'b0;
      rxd    <= 1'b0;
      evt    <= '0;
    end else begin
      evt <= '0;
      if (start_ok) begin
        in_txn <= 1'b1;
        txd    <= 1'b0;
        rxd    <= 1'b0;
      end else begin
        if (tx_fire) begin
          txd                     <= 1'b1;
          evt.transmit_done_event <= 1'b1;
        end
        if (rx_fire) begin
          rxd                    <= 1'b1;
          evt.receive_done_event <= 1'b1;
        end
        if (in_txn && txd && rxd) begin
          in_txn        <= 1'b0;
          evt.end_event <= 1'b1;
        end
        if (state == s_halt) begin
          evt.stopped_event <= 1'b1;
        end
      end
    end
  end

  smtc_pins #(
    .PW (PW)
  ) u_pins (
    .mclk     (mclk),
    .nrst     (nrst),
    .enable   (enable),
    .psel     (psel),
    .sck_lvl  (sck_lvl),
    .mosi_lvl (mosi_q),
    .pin_in   (pin_in),
    .pin_out  (pin_out),
    .pin_oe_n (pin_oe_n),
    .miso_s   (miso_s)
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_start_runs: assert property (
    start_ok && transmit_byte_limit != '0 |=> state == s_load ##1 in_txn
  ) else $error("start did not launch a transfer");

  a_tx_done_count: assert property (
    evt.transmit_done_event |-> bcnt >= txlim_q || $past(state) == s_halt
  ) else $error("transmit done before limit");

  a_rx_done_count: assert property (
    evt.receive_done_event |-> bcnt >= rxlim_q || $past(state) == s_halt
  ) else $error("receive done before limit");

  a_end_both: assert property (
    evt.end_event |-> $past(txd && rxd && in_txn) && !in_txn
  ) else $error("end without both done events");

  a_stop_halts: assert property (
    stop_task && (state == s_load || state == s_shift)
      |=> state == s_halt && !sck_act ##1 evt.stopped_event
  ) else $error("stop did not halt");

  a_stop_rx_flush: assert property (
    state == s_halt && in_txn && !rxd |=> evt.receive_done_event
  ) else $error("receive done missing at stop");

  a_stop_tx_flush: assert property (
    state == s_halt && in_txn && !txd |=> evt.transmit_done_event
  ) else $error("transmit done missing at stop");

  a_byte_eight: assert property (
    rx_valid |-> $past(bitn) == 3'h7 && $past(sck_act)
      && $past(state) == s_shift
  ) else $error("byte ended off the eighth bit");

  a_idle_lines: assert property (
    state == s_idle |-> !sck_act && mosi_q == `SMTC_MOSI_IDLE
      && sck_lvl == cfg.mode[1]
  ) else $error("lines not idle");

  c_end_seen: cover property (evt.end_event);
  c_forced_stop: cover property (
    state == s_halt && in_txn && !txd && !rxd
  );
  c_mode3_byte: cover property (rx_valid && mode_q == bus_mode_three);
  c_over_read: cover property (state == s_load && !tx_more && rx_valid);

endmodule

// File: rtl/smtc_defines.svh
// Constants for the serial master transaction core
`ifndef SMTC_DEFINES_SVH
`define SMTC_DEFINES_SVH

// System clock period in ps and serial clock period in ns
`define SMTC_CLK_PERIOD_PS 5000
`define SMTC_SCK_PERIOD_NS 125
// Half serial clock period in system cycles, rounded down
`define SMTC_SCK_HALF_CYC \
  ((`SMTC_SCK_PERIOD_NS * 1000) / (2 * `SMTC_CLK_PERIOD_PS))
`define SMTC_CNT_W 16
`define SMTC_PSEL_W 5
`define SMTC_MOSI_IDLE 1'b0
`define SMTC_BIT_LAST 3'h7

`endif

// File: rtl/smtc_pins.sv
// Pin routing and input synchronisers of the serial master
`timescale 1ns/1ps
`include "smtc_defines.svh"
module smtc_pins
  import smtc_pkg::*;
#(
  parameter int PW = `SMTC_PSEL_W
) (
  input  logic               mclk,
  input  logic               nrst,
  input  logic               enable,
  input  smtc_psel_s         psel,
  input  logic               sck_lvl,
  input  logic               mosi_lvl,
  input  logic [(1<<PW)-1:0] pin_in,
  output logic [(1<<PW)-1:0] pin_out,
  output logic [(1<<PW)-1:0] pin_oe_n,
  output logic               miso_s
);

  localparam int NPIN = 1 << PW;

  logic [NPIN-1:0] sync1;
  logic [NPIN-1:0] sync2;

  // Only clock and data out are ever driven; no select line exists
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pin_out  <= '0;
      pin_oe_n <= '1;
    end else begin
      for (int i = 0; i < NPIN; i++) begin
        pin_out[i]  <= 1'b0;
        pin_oe_n[i] <= 1'b1;
        if (enable && psel.sck == PW'(i)) begin
          pin_out[i]  <= sck_lvl;
          pin_oe_n[i] <= 1'b0;
        end
        if (enable && psel.mosi == PW'(i)) begin
          pin_out[i]  <= mosi_lvl;
          pin_oe_n[i] <= 1'b0;
        end
      end
    end
  end

  // Every pin is synchronised so the data-in choice needs no resync
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
    end
  end

  assign miso_s = sync2[psel.miso];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_pins_released: assert property (
    !enable |=> pin_oe_n == '1
  ) else $error("pins driven while disabled");

  a_sck_routed: assert property (
    enable |=> !pin_oe_n[$past(psel.sck)]
      && pin_out[$past(psel.sck)] == $past(sck_lvl)
  ) else $error("clock level not on selected pin");

endmodule

// File: rtl/smtc_pkg.sv
// Types shared by the serial master transaction core
`include "smtc_defines.svh"
package smtc_pkg;

  // Bit 1 is the clock polarity, bit 0 the clock phase
  typedef enum logic [1:0] {
    bus_mode_zero,
    bus_mode_one,
    bus_mode_two,
    bus_mode_three
  } smtc_mode_e;

  typedef struct packed {
    smtc_mode_e mode;
    logic       lsb_first;
  } smtc_cfg_s;

  typedef struct packed {
    logic [`SMTC_PSEL_W-1:0] sck;
    logic [`SMTC_PSEL_W-1:0] mosi;
    logic [`SMTC_PSEL_W-1:0] miso;
  } smtc_psel_s;

  typedef struct packed {
    logic transmit_done_event;
    logic receive_done_event;
    logic end_event;
    logic stopped_event;
  } smtc_evt_s;

  typedef enum logic [1:0] {
    s_idle,
    s_load,
    s_shift,
    s_halt
  } smtc_state_e;

endpackage
